// ===== ebsh_pkg.sv
// Constants for the external bus select and hold block.
// Assumes a 20-bit external address and a 24-bit internal address space.
`default_nettype none
package ebsh_pkg;
    localparam int NUM_CS = 6;
    localparam int ADDR_W = 24;
    // Reset range of the first chip select (internal view)
    localparam logic [23:0] CS0_RST_BASE = 24'hFF_2000;
    localparam logic [23:0] CS0_RST_TOP = 24'hFF_20FF;
    // Special-purpose and program partition
    localparam logic [23:0] SPP_LO = 24'hFF_2000;
    localparam logic [23:0] SPP_HI = 24'hFF_DFFF;
    // Ranges of unprogrammed selects: empty (base above top)
    localparam logic [23:0] CS_RST_BASE = 24'hFF_FFFF;
    localparam logic [23:0] CS_RST_TOP = 24'h00_0000;
    // Port 2 pin positions of shared functions
    localparam int P2_BUS_REQUEST_N_BIT = 3;
    localparam int P2_HOLD_BIT = 5;
    localparam int P2_HOLD_ACK_N_BIT = 6;
    localparam int P2_CLK_BIT = 7;
    // Index of the chip select whose bus configuration is the default
    localparam logic [2:0] DEFAULT_CFG_CS = 3'h5;
    typedef enum logic [2:0] {
        BUS_OWN = 3'b001,
        BUS_RELEASE = 3'b010,
        BUS_HELD = 3'b100
    } ebsh_hold_t;
endpackage
`default_nettype wire

// ===== ebsh_cs_decode.sv
// Chip-select range decoder with lowest-index priority.
// Assumes ranges are inclusive and compared on the full internal address.
`timescale 1ns/10ps
`default_nettype none
module ebsh_cs_decode
    import ebsh_pkg::*;
#(
    parameter int NCS = NUM_CS
) (
    // Address and ranges
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [NCS*ADDR_W-1:0] rangeBase,
    input wire logic [NCS*ADDR_W-1:0] rangeTop,
    // Result
    output logic [NCS-1:0] hitOneHot,
    output logic anyHit,
    output logic [2:0] hitIndex
);
    logic [NCS-1:0] rawHit;
    for (genvar i = 0; i < NCS; i++) begin : g_cmp
        assign rawHit[i] = (addr >= rangeBase[i*ADDR_W +: ADDR_W]) &&
                           (addr <= rangeTop[i*ADDR_W +: ADDR_W]);
    end
    // Keep only the lowest set bit
    assign hitOneHot = rawHit & (~rawHit + NCS'(1));
    assign anyHit = |rawHit;
    always_comb begin
        hitIndex = DEFAULT_CFG_CS;
        for (int j = NCS - 1; j >= 0; j--) begin
            if (rawHit[j]) begin
                hitIndex = 3'(j);
            end
        end
    end
endmodule
`default_nettype wire

// ===== ebsh_top.sv
// Bus steering: chip selects, internal/external routing, bus hold, half-rate clock.
// Assumes the bus controller presents one access request with its address,
// held until accepted; ranges come from a chip-select unit outside.
//
// Function
// - Bus request asserted when cycle pending during hold
// - Hold enable dedicates port 2 request pin
// - Pin reconfiguration ignored while hold enabled
// - Half-rate, 50% duty clock output on port pin
// - Lowest-index in-range chip select asserted, on an external cycle only
// - No match: no select, sixth select configuration
// - First select resets to FF2000-FF20FF range
// - Partition internal unless external access asserted
// - Other addresses ignore external access input
// - External access input evaluated live, not latched
// - Hold acknowledge only after bus released
`timescale 1ns/10ps
`default_nettype none
module ebsh_top
    import ebsh_pkg::*;
#(
    parameter int NCS = NUM_CS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Bus controller side
    input wire logic accReq,
    input wire logic [ADDR_W-1:0] accAddr,
    input wire logic accDone,
    output logic accExternal,
    output logic accInternal,
    output logic [2:0] accCfgIndex,
    // Chip-select range programming
    input wire logic csProgWe,
    input wire logic [2:0] csProgIdx,
    input wire logic [ADDR_W-1:0] csProgBase,
    input wire logic [ADDR_W-1:0] csProgTop,
    // Control
    input wire logic hold_protocol_enable_bit,
    input wire logic [7:0] port2_function_select,
    input wire logic [7:0] port2_direction_select,
    input wire logic [7:0] port2_output_value,
    input wire logic [7:0] port2PinIn,
    // External pins
    input wire logic external_access_n,
    input wire logic holdReqN,
    output logic [NCS-1:0] chip_select_n,
    output logic [7:0] port2PinOut,
    output logic [7:0] port2PinOe,
    output logic busReleased
);
    // ******************************************
    // Parameter check
    // ******************************************
    // Select index and one-hot outputs serve one to eight selects
    if (NCS < 1 || NCS > 8) begin : g_bad_ncs
        $error("NCS out of range");
    end

    // ******************************************
    // Chip-select ranges
    // ******************************************
    // Writes to a select index of NCS or above are dropped
    logic [NCS*ADDR_W-1:0] baseQ, topQ;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            for (int i = 0; i < NCS; i++) begin
                baseQ[i*ADDR_W +: ADDR_W] <= (i == 0) ? CS0_RST_BASE : CS_RST_BASE;
                topQ[i*ADDR_W +: ADDR_W] <= (i == 0) ? CS0_RST_TOP : CS_RST_TOP;
            end
        end else if (csProgWe && int'(csProgIdx) < NCS) begin
            baseQ[csProgIdx*ADDR_W +: ADDR_W] <= csProgBase;
            topQ[csProgIdx*ADDR_W +: ADDR_W] <= csProgTop;
        end
    end

    // ******************************************
    // Routing and decode
    // ******************************************
    logic [NCS-1:0] hitOneHot;
    logic anyHit;
    logic [2:0] hitIndex;
    ebsh_cs_decode #(.NCS(NCS)) u_dec (
        .addr(accAddr),
        .rangeBase(baseQ),
        .rangeTop(topQ),
        .hitOneHot(hitOneHot),
        .anyHit(anyHit),
        .hitIndex(hitIndex)
    );
    // Inclusive window test on the internal address
    function automatic logic in_window(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] lo,
                                       input logic [ADDR_W-1:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    wire inPartition = in_window(accAddr, SPP_LO, SPP_HI);
    // Live pin, no latch; outside the partition all accesses go external
    wire goExternal = inPartition ? !external_access_n : 1'b1;

    // ******************************************
    // Bus hold protocol
    // ******************************************
    ebsh_hold_t stQ, stD;
    wire holdEn = hold_protocol_enable_bit;
    wire holdReq = holdEn && !holdReqN;
    logic busyQ;
    always_comb begin
        stD = stQ;
        unique case (stQ)
            BUS_OWN: if (holdReq) stD = BUS_RELEASE;
            BUS_RELEASE: if (!busyQ || accDone) stD = BUS_HELD;
            BUS_HELD: if (!holdReq) stD = BUS_OWN;
            default: stD = BUS_OWN;
        endcase
    end
    // Only a bus this block owns may start an external cycle
    wire extCycle = accReq && goExternal && stQ == BUS_OWN;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            stQ <= BUS_OWN;
            busyQ <= 1'b0;
        end else begin
            stQ <= stD;
            busyQ <= accDone ? 1'b0 : (extCycle ? 1'b1 : busyQ);
        end
    end
    // A cycle left waiting while the bus is lent out
    wire pendExt = accReq && goExternal && stQ != BUS_OWN;

    // ******************************************
    // Port 2 configuration, shadowed while hold is on
    // ******************************************
    // Writes land only while hold is off, taken up the cycle after it clears
    logic [7:0] modeQ, dirQ, valQ;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            modeQ <= 8'h00;
            dirQ <= 8'h00;
            valQ <= 8'h00;
        end else if (!holdEn) begin
            modeQ <= port2_function_select;
            dirQ <= port2_direction_select;
            valQ <= port2_output_value;
        end
    end

    // ******************************************
    // Half-rate clock and registered outputs
    // ******************************************
    logic clkDivQ;
    always_ff @(posedge clk_sys) begin
        if (!nrst) clkDivQ <= 1'b0;
        else clkDivQ <= !clkDivQ;
    end
    wire heldNext = (stD == BUS_HELD);
    // Pin levels of the hold handshake, active low
    wire busReqN = !pendExt;
    wire holdAckN = !heldNext;

    logic [7:0] p2OutD, p2OeD;
    always_comb begin
        p2OutD = valQ;
        p2OeD = dirQ;
        if (modeQ[P2_CLK_BIT]) begin
            p2OutD[P2_CLK_BIT] = !clkDivQ;
            p2OeD[P2_CLK_BIT] = 1'b1;
        end
        if (holdEn) begin
            p2OutD[P2_BUS_REQUEST_N_BIT] = busReqN;
            p2OeD[P2_BUS_REQUEST_N_BIT] = 1'b1;
            p2OutD[P2_HOLD_ACK_N_BIT] = holdAckN;
            p2OeD[P2_HOLD_ACK_N_BIT] = 1'b1;
            p2OutD[P2_HOLD_BIT] = 1'b0;
            p2OeD[P2_HOLD_BIT] = 1'b0;
        end
    end

    // ******************************************
    // Next values of the access outputs
    // ******************************************
    // Selects fire only for a bus cycle this block runs itself
    wire [NCS-1:0] csNextN = (extCycle && anyHit) ? ~hitOneHot : '1;
    // Unmatched cycles fall back to the sixth select's bus configuration
    wire [2:0] cfgNext = anyHit ? hitIndex : DEFAULT_CFG_CS;
    wire intNext = accReq && !goExternal;

    // ******************************************
    // Registered outputs
    // ******************************************
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            chip_select_n <= '1;
            accExternal <= 1'b0;
            accInternal <= 1'b0;
            accCfgIndex <= DEFAULT_CFG_CS;
        end else begin
            chip_select_n <= csNextN;
            accExternal <= extCycle;
            accInternal <= intNext;
            accCfgIndex <= cfgNext;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            port2PinOut <= 8'h00;
            port2PinOe <= 8'h00;
            busReleased <= 1'b0;
        end else begin
            port2PinOut <= p2OutD;
            port2PinOe <= p2OeD;
            busReleased <= heldNext;
        end
    end
endmodule
`default_nettype wire

// ===== ebsh_top_asserts.sv
// Port assertions for ebsh_top.
// Assumes a bind to ebsh_top and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module ebsh_top_chk
    import ebsh_pkg::*;
#(parameter int NCS = NUM_CS) (
    input wire logic clk_sys, nrst, accReq, accExternal, accInternal,
    input wire logic hold_protocol_enable_bit, external_access_n, holdReqN, busReleased,
    input wire logic [ADDR_W-1:0] accAddr,
    input wire logic [2:0] accCfgIndex,
    input wire logic [NCS-1:0] chip_select_n,
    input wire logic [7:0] port2PinOut
);
    wire logic inSpp = accAddr >= SPP_LO && accAddr <= SPP_HI;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_cs_onehot: assert property ($onehot0(~chip_select_n)) else $error("two selects");
    a_cs_external: assert property (!(&chip_select_n) |-> accExternal) else $error("stray select");
    a_nohit_cfg: assert property (accExternal && &chip_select_n |-> accCfgIndex == DEFAULT_CFG_CS)
        else $error("bad config");
    a_spp_internal: assert property (accReq && inSpp && external_access_n |=> accInternal)
        else $error("not internal");
    a_ea_live: assert property (accReq && inSpp && !external_access_n |=> !accInternal)
        else $error("not external");
    a_out_spp: assert property (accReq && !inSpp |=> !accInternal) else $error("wrong route");
    a_ack_held: assert property ($past(nrst) && $past(hold_protocol_enable_bit) &&
        hold_protocol_enable_bit && !port2PinOut[6] |-> busReleased) else $error("early ack");
    a_bus_request_n_pend: assert property (busReleased && !holdReqN && accReq && !inSpp |-> ##[1:2] !port2PinOut[3])
        else $error("no request");
endmodule
bind ebsh_top ebsh_top_chk #(.NCS(NCS)) u_chk (.*);
`default_nettype wire

// ===== ebsh_hold_master.sv
// Outside bus master that asks for the bus by the hold request pin.
// Assumes the bench says when the bus is wanted.
`timescale 1ns/10ps
`default_nettype none
module ebsh_hold_master (
    input wire logic clk_sys,
    input wire logic wantBus,
    output logic holdReqN
);
    initial holdReqN = 1'b1;
    always @(posedge clk_sys) holdReqN <= !wantBus;
endmodule
`default_nettype wire

// ===== testbench.sv
// Bench for ebsh_top: selects, routing, hold handshake, half-rate clock.
// Assumes ebsh_hold_master plays the outside bus master.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ebsh_pkg::*;
    logic clk_sys = 0, nrst = 0, accReq = 0, accDone = 0, csProgWe = 0, wantBus = 0;
    logic hold_protocol_enable_bit = 0, external_access_n = 1;
    logic [23:0] accAddr = 0, csProgBase = 0, csProgTop = 0;
    logic [2:0] csProgIdx = 0;
    logic [7:0] port2_function_select = 0;
    logic holdReqN, accExternal, accInternal, busReleased;
    logic [2:0] accCfgIndex;
    logic [5:0] chip_select_n;
    logic [7:0] port2PinOut, port2PinOe;
    int n_fail = 0, compares = 0, cyc = 0;
    always #2.5 clk_sys = !clk_sys;
    ebsh_top dut (.*, .port2_direction_select(8'h00), .port2_output_value(8'h00), .port2PinIn(8'h00));
    ebsh_hold_master u_master (.clk_sys(clk_sys), .wantBus(wantBus), .holdReqN(holdReqN));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic [23:0] a, input logic eaN);
        @(posedge clk_sys);
        accReq <= 1'b1;
        accAddr <= a;
        external_access_n <= eaN;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic acc_end;
        @(posedge clk_sys);
        accReq <= 1'b0;
        accDone <= 1'b1;
        @(posedge clk_sys);
        accDone <= 1'b0;
    endtask
    task automatic prog(input logic [2:0] i, input logic [23:0] b, input logic [23:0] t);
        @(posedge clk_sys);
        csProgWe <= 1'b1;
        csProgIdx <= i;
        csProgBase <= b;
        csProgTop <= t;
        @(posedge clk_sys);
        csProgWe <= 1'b0;
    endtask
    task automatic t_decode;
        #1 chk(chip_select_n, 6'h3F);
        acc(24'hFF_2050, 1'b0);
        chk(chip_select_n, 6'h3E);
        acc_end;
        acc(24'hFF_2100, 1'b0);
        chk(chip_select_n, 6'h3F);
        chk(accCfgIndex, DEFAULT_CFG_CS);
        acc(24'hFF_2100, 1'b1);
        chk(accInternal, 1'b1);
        acc(24'hFF_2100, 1'b0);
        chk(accInternal, 1'b0);
        acc_end;
        prog(3'h2, 24'h01_0000, 24'h01_FFFF);
        prog(3'h1, 24'h01_8000, 24'h01_8FFF);
        acc(24'h01_8800, 1'b1);
        chk(chip_select_n, 6'h3D);
        acc_end;
        acc(24'h01_0100, 1'b1);
        chk(chip_select_n, 6'h3B);
        chk(accExternal, 1'b1);
        acc_end;
        $display("t_decode done");
    endtask
    task automatic t_clock;
        logic p;
        @(posedge clk_sys);
        port2_function_select <= 8'h80;
        repeat (3) @(posedge clk_sys);
        repeat (4) begin
            #1 p = port2PinOut[7];
            @(posedge clk_sys);
            #1 chk(port2PinOut[7], !p);
        end
        $display("t_clock done");
    endtask
    task automatic t_hold;
        @(posedge clk_sys);
        hold_protocol_enable_bit <= 1'b1;
        wantBus <= 1'b1;
        for (int i = 0; i < 20 && busReleased !== 1'b1; i++) @(posedge clk_sys);
        #1 chk(port2PinOut[6], 1'b0);
        chk({port2PinOe[6], port2PinOe[5], port2PinOe[3]}, 3'b101);
        acc(24'h00_1000, 1'b1);
        chk(port2PinOut[3], 1'b0);
        chk(chip_select_n, 6'h3F);
        @(posedge clk_sys);
        port2_function_select <= 8'h00;
        repeat (2) @(posedge clk_sys);
        #1 chk(port2PinOe[7], 1'b1);
        @(posedge clk_sys);
        wantBus <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 chk(busReleased, 1'b0);
        acc_end;
        hold_protocol_enable_bit <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 chk(port2PinOe[7], 1'b0);
        $display("t_hold done");
    endtask
    task automatic tally_and_finish;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 600) begin
            n_fail++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        t_decode;
        t_clock;
        t_hold;
        tally_and_finish;
    end
endmodule
`default_nettype wire
